// >>> inc/daqtr_pkg.sv
// Shared constants, selector encodings and carrier structs for the trigger routing block
package daqtr_pkg;

  // System clock and derived counter timebases
  localparam int CLK_HZ = 50_000_000;
  localparam int FAST_CLK_HZ = 10_000_000;
  localparam int SLOW_CLK_HZ = 100_000;
  localparam int FAST_DIV = CLK_HZ / FAST_CLK_HZ;
  localparam int SLOW_DIV = CLK_HZ / SLOW_CLK_HZ;

  // Sizes
  localparam int AUX_IN_N = 6;
  localparam int AUX_OUT_N = 3;
  localparam int CTR_N = 2;
  localparam int CTR_BITS = 16;
  localparam int IRQ_N = 11;
  localparam int AIN_SEL_W = 3;
  localparam int AOUT_SEL_W = 4;
  localparam int CCLK_SEL_W = 2;

  // Interrupt source positions in the enable, pending and clear vectors
  localparam int IRQ_ACQ_RUNNING = 0;
  localparam int IRQ_ACQ_HALT = 1;
  localparam int IRQ_ACQ_COMPLETE = 2;
  localparam int IRQ_IN_QUARTER = 3;
  localparam int IRQ_PER_SAMPLE = 4;
  localparam int IRQ_END_OF_SCAN = 5;
  localparam int IRQ_END_OF_INTERVAL = 6;
  localparam int IRQ_WAVE_RUNNING = 7;
  localparam int IRQ_WAVE_COMPLETE = 8;
  localparam int IRQ_OUT_QUARTER = 9;
  localparam int IRQ_HIGH_CHANNEL = 10;

  // Function that an auxiliary input drives
  typedef enum logic [AIN_SEL_W-1:0] {
    AIN_ADC_CONVERT, AIN_ADC_TIMEBASE, AIN_ADC_START, AIN_ADC_STOP,
    AIN_ADC_GATE, AIN_DAC_START, AIN_DAC_UPDATE, AIN_DAC_TIMEBASE
  } daqtr_ain_e;

  // Internal signal that an auxiliary output shows
  typedef enum logic [AOUT_SEL_W-1:0] {
    AOUT_SCAN_BEGIN, AOUT_SAMPLE_HOLD, AOUT_ACQ_STOP, AOUT_ADC_CONVERT,
    AOUT_DELAYED_CONVERT, AOUT_CTR1_CLK, AOUT_DAC_UPDATE, AOUT_CTR2_CLK,
    AOUT_ADC_START_ECHO, AOUT_ADC_STOP_ECHO, AOUT_DAC_START_ECHO
  } daqtr_aout_e;

  // Counter clock source
  typedef enum logic [CCLK_SEL_W-1:0] {
    CCLK_FAST, CCLK_SLOW, CCLK_EXT
  } daqtr_cclk_e;

  // Power-on selections software is expected to load into the selector ports
  localparam logic [AUX_IN_N-1:0][AIN_SEL_W-1:0] AIN_SEL_DEFAULT = {
    AIN_ADC_GATE, AIN_DAC_START, AIN_DAC_UPDATE, AIN_ADC_STOP, AIN_ADC_START, AIN_ADC_CONVERT
  };
  localparam logic [AUX_OUT_N-1:0][AOUT_SEL_W-1:0] AOUT_SEL_DEFAULT = {
    AOUT_DELAYED_CONVERT, AOUT_ADC_CONVERT, AOUT_DAC_UPDATE
  };

  // Events from the acquisition and waveform sequencers, same clock
  typedef struct packed {
    logic acq_active;
    logic acq_done;
    logic in_quarter;
    logic sample_done;
    logic scan_end;
    logic interval_end;
    logic dac_active;
    logic dac_done;
    logic out_quarter;
    logic high_ch_update;
    logic scan_start;
    logic adc_convert;
    logic last_conv_start;
    logic delayed_convert;
    logic dac_update;
  } daqtr_evt_s;

  // Routed auxiliary-input functions towards the sequencers
  typedef struct packed {
    logic adc_convert;
    logic adc_timebase;
    logic adc_start;
    logic adc_stop;
    logic adc_gate;
    logic dac_start;
    logic dac_gate;
    logic dac_update;
    logic dac_timebase;
  } daqtr_route_s;

endpackage

// >>> rtl/daqtr_top.sv
// Trigger routing, counter clock selection and interrupt raising for the acquisition board
`timescale 1ns/1ns
module daqtr_top #(
  parameter int FAST_DIV_P = daqtr_pkg::FAST_DIV,
  parameter int SLOW_DIV_P = daqtr_pkg::SLOW_DIV
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Auxiliary trigger pins
  input wire logic [daqtr_pkg::AUX_IN_N-1:0] aux_trigger_input_i,
  output logic [daqtr_pkg::AUX_OUT_N-1:0] aux_trigger_output_o,
  // Auxiliary configuration
  input wire logic [daqtr_pkg::AUX_IN_N-1:0][daqtr_pkg::AIN_SEL_W-1:0] ain_sel_i,
  input wire logic [daqtr_pkg::AUX_IN_N-1:0] ain_invert_i,
  input wire logic [daqtr_pkg::AUX_OUT_N-1:0][daqtr_pkg::AOUT_SEL_W-1:0] aout_sel_i,
  input wire logic [daqtr_pkg::AUX_OUT_N-1:0] aout_invert_i,
  input wire logic dac_gate_edge_mode_i,
  input wire logic dac_gate_clear_i,
  // Sequencer events and routed functions
  input wire daqtr_pkg::daqtr_evt_s evt_i,
  output daqtr_pkg::daqtr_route_s route_o,
  output logic scan_begin_pulse_o,
  output logic sample_hold_window_o,
  output logic acq_stop_o,
  // Counter clocks
  input wire logic [daqtr_pkg::CTR_N-1:0] counter_ext_clock_i,
  input wire logic [daqtr_pkg::CTR_N-1:0][daqtr_pkg::CCLK_SEL_W-1:0] ctr_clk_sel_i,
  output logic [daqtr_pkg::CTR_N-1:0] ctr_clk_en_o,
  // Interrupts
  input wire logic [daqtr_pkg::IRQ_N-1:0] irq_enable_i,
  input wire logic [daqtr_pkg::IRQ_N-1:0] irq_clear_i,
  output logic [daqtr_pkg::IRQ_N-1:0] irq_pending_o,
  output logic pci_inta_n_o,
  output logic pci_inta_oe_n_o
);
  import daqtr_pkg::*;

  localparam int FAST_W = $clog2(FAST_DIV_P);
  localparam int SLOW_W = $clog2(SLOW_DIV_P);
  localparam logic [FAST_W-1:0] FAST_LAST = FAST_W'(FAST_DIV_P - 1);
  localparam logic [SLOW_W-1:0] SLOW_LAST = SLOW_W'(SLOW_DIV_P - 1);

  // Auxiliary input path: synchroniser pair, edge history and
  // the polarity-corrected level and edge seen by the routing.
  // Only the second flop of each pair feeds any logic, so a
  // metastable first stage never fans out into the selectors.
  logic [AUX_IN_N-1:0] ain_meta_reg;
  logic [AUX_IN_N-1:0] ain_sync_reg;
  logic [AUX_IN_N-1:0] ain_prev_reg;
  logic [AUX_IN_N-1:0] ain_edge;
  logic [AUX_IN_N-1:0] ain_level;

  // External counter clock path, same structure as the aux inputs.
  // Only rising edges are used; the counter core counts enables,
  // so the pin never clocks any flop directly.
  logic [CTR_N-1:0] cext_meta_reg;
  logic [CTR_N-1:0] cext_sync_reg;
  logic [CTR_N-1:0] cext_prev_reg;
  logic [CTR_N-1:0] cext_rise;

  // Internal timebase dividers and the per-counter tick choice.
  // Ticks are one-cycle enables rather than derived clocks, which
  // keeps the whole block in a single clock domain.
  logic [FAST_W-1:0] fast_cnt_reg;
  logic [SLOW_W-1:0] slow_cnt_reg;
  logic fast_en_reg;
  logic slow_en_reg;
  logic [CTR_N-1:0] ctr_clk_next;

  // Routed functions before their output register, and the
  // edge-mode gate latch for the output pacer.
  daqtr_route_s route_next;
  logic dac_gate_latch_reg;

  // Interrupt raising: threshold history for the two buffer
  // levels, the raw source vector and the next pending state.
  // Level sources re-arm pending every cycle they stay active,
  // so software must remove the cause before clearing.
  logic in_quarter_prev_reg;
  logic out_quarter_prev_reg;
  logic [IRQ_N-1:0] irq_src;
  logic [IRQ_N-1:0] pending_next;

  // Auxiliary outputs before their register; selector codes with
  // no source defined give a constant low before inversion.
  logic [AUX_OUT_N-1:0] aout_next;

  // Pins come from outside the clock domain: two flops, then a third for edges
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ain_meta_reg <= '0;
      ain_sync_reg <= '0;
      ain_prev_reg <= '0;
    end else begin
      ain_meta_reg <= aux_trigger_input_i;
      ain_sync_reg <= ain_meta_reg;
      ain_prev_reg <= ain_sync_reg;
    end
  end

  // Invert makes falling edges and low levels look like rising edges and high levels
  always_comb begin
    for (int i = 0; i < AUX_IN_N; i++) begin
      ain_level[i] = ain_sync_reg[i] ^ ain_invert_i[i];
      ain_edge[i] = ain_level[i] & ~(ain_prev_reg[i] ^ ain_invert_i[i]);
    end
  end

  // Input routing; several pins on one function are ORed together
  always_comb begin
    route_next = '0;
    for (int i = 0; i < AUX_IN_N; i++) begin
      case (daqtr_ain_e'(ain_sel_i[i]))
        AIN_ADC_CONVERT: route_next.adc_convert |= ain_edge[i];
        AIN_ADC_TIMEBASE: route_next.adc_timebase |= ain_edge[i];
        AIN_ADC_START: route_next.adc_start |= ain_edge[i];
        AIN_ADC_STOP: route_next.adc_stop |= ain_edge[i];
        AIN_ADC_GATE: route_next.adc_gate |= ain_level[i];
        AIN_DAC_START: begin
          route_next.dac_start |= ain_edge[i];
          if (!dac_gate_edge_mode_i) begin
            route_next.dac_gate |= ain_level[i];
          end
        end
        AIN_DAC_UPDATE: route_next.dac_update |= ain_edge[i];
        AIN_DAC_TIMEBASE: route_next.dac_timebase |= ain_edge[i];
        default: ;
      endcase
    end
    if (dac_gate_edge_mode_i) begin
      route_next.dac_gate = dac_gate_latch_reg | route_next.dac_start;
    end
  end

  // Edge-mode gate opens on the start edge and stays open until software closes it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_gate_latch_reg <= 1'b0;
    end else if (!dac_gate_edge_mode_i) begin
      dac_gate_latch_reg <= 1'b0;
    end else if (route_next.dac_start) begin
      dac_gate_latch_reg <= 1'b1;
    end else if (dac_gate_clear_i) begin
      dac_gate_latch_reg <= 1'b0;
    end
  end

  // Routed functions registered so the sequencers see clean flop outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_o <= '0;
    end else begin
      route_o <= route_next;
    end
  end

  // Dividers for the internal counter timebases, one-cycle enables.
  // Both run free from reset; the phase of a tick relative to a
  // source switch is not defined, so a counter may see one short
  // first period after its selector changes.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fast_cnt_reg <= '0;
      fast_en_reg <= 1'b0;
    end else begin
      fast_en_reg <= (fast_cnt_reg == FAST_LAST);
      fast_cnt_reg <= (fast_cnt_reg == FAST_LAST) ? '0 : fast_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_cnt_reg <= '0;
      slow_en_reg <= 1'b0;
    end else begin
      slow_en_reg <= (slow_cnt_reg == SLOW_LAST);
      slow_cnt_reg <= (slow_cnt_reg == SLOW_LAST) ? '0 : slow_cnt_reg + 1'b1;
    end
  end

  // External counter clocks; limited to well under half the system rate
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cext_meta_reg <= '0;
      cext_sync_reg <= '0;
      cext_prev_reg <= '0;
    end else begin
      cext_meta_reg <= counter_ext_clock_i;
      cext_sync_reg <= cext_meta_reg;
      cext_prev_reg <= cext_sync_reg;
    end
  end

  assign cext_rise = cext_sync_reg & ~cext_prev_reg;

  // Counter clock source selection.
  // The unused selector code gives no ticks at all, which lets
  // software park a counter without touching its gate pin.
  always_comb begin
    for (int n = 0; n < CTR_N; n++) begin
      case (daqtr_cclk_e'(ctr_clk_sel_i[n]))
        CCLK_FAST: ctr_clk_next[n] = fast_en_reg;
        CCLK_SLOW: ctr_clk_next[n] = slow_en_reg;
        CCLK_EXT: ctr_clk_next[n] = cext_rise[n];
        default: ctr_clk_next[n] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctr_clk_en_o <= '0;
    end else begin
      ctr_clk_en_o <= ctr_clk_next;
    end
  end

  // Scan-level outputs derived from sequencer events
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_begin_pulse_o <= 1'b0;
      acq_stop_o <= 1'b0;
    end else begin
      scan_begin_pulse_o <= evt_i.scan_start;
      acq_stop_o <= evt_i.scan_end;
    end
  end

  // Clear wins so a one-channel scan never opens the window
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_hold_window_o <= 1'b0;
    end else if (evt_i.last_conv_start) begin
      sample_hold_window_o <= 1'b0;
    end else if (evt_i.scan_start) begin
      sample_hold_window_o <= 1'b1;
    end
  end

  // Output source selection, one cycle behind the selected signal
  always_comb begin
    for (int k = 0; k < AUX_OUT_N; k++) begin
      case (daqtr_aout_e'(aout_sel_i[k]))
        AOUT_SCAN_BEGIN: aout_next[k] = evt_i.scan_start;
        AOUT_SAMPLE_HOLD: aout_next[k] = sample_hold_window_o;
        AOUT_ACQ_STOP: aout_next[k] = evt_i.scan_end;
        AOUT_ADC_CONVERT: aout_next[k] = evt_i.adc_convert;
        AOUT_DELAYED_CONVERT: aout_next[k] = evt_i.delayed_convert;
        AOUT_CTR1_CLK: aout_next[k] = ctr_clk_next[0];
        AOUT_DAC_UPDATE: aout_next[k] = evt_i.dac_update;
        AOUT_CTR2_CLK: aout_next[k] = ctr_clk_next[1];
        AOUT_ADC_START_ECHO: aout_next[k] = route_next.adc_start;
        AOUT_ADC_STOP_ECHO: aout_next[k] = route_next.adc_stop;
        AOUT_DAC_START_ECHO: aout_next[k] = route_next.dac_start;
        default: aout_next[k] = 1'b0;
      endcase
      aout_next[k] = aout_next[k] ^ aout_invert_i[k];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_trigger_output_o <= '0;
    end else begin
      aux_trigger_output_o <= aout_next;
    end
  end

  // Buffer thresholds are levels; only the crossing raises an event
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_quarter_prev_reg <= 1'b0;
      out_quarter_prev_reg <= 1'b0;
    end else begin
      in_quarter_prev_reg <= evt_i.in_quarter;
      out_quarter_prev_reg <= evt_i.out_quarter;
    end
  end

  // Interrupt sources.
  // The halt source follows the routed stop edge, so it only fires
  // when some auxiliary input has been assigned the stop function.
  always_comb begin
    irq_src = '0;
    irq_src[IRQ_ACQ_RUNNING] = evt_i.acq_active;
    irq_src[IRQ_ACQ_HALT] = route_next.adc_stop;
    irq_src[IRQ_ACQ_COMPLETE] = evt_i.acq_done;
    irq_src[IRQ_IN_QUARTER] = evt_i.in_quarter & ~in_quarter_prev_reg;
    irq_src[IRQ_PER_SAMPLE] = evt_i.sample_done;
    irq_src[IRQ_END_OF_SCAN] = evt_i.scan_end;
    irq_src[IRQ_END_OF_INTERVAL] = evt_i.interval_end;
    irq_src[IRQ_WAVE_RUNNING] = evt_i.dac_active;
    irq_src[IRQ_WAVE_COMPLETE] = evt_i.dac_done;
    irq_src[IRQ_OUT_QUARTER] = evt_i.out_quarter & ~out_quarter_prev_reg;
    irq_src[IRQ_HIGH_CHANNEL] = evt_i.high_ch_update;
  end

  // Sticky pending bits; a new event beats a clear in the same cycle
  assign pending_next = (irq_pending_o & ~irq_clear_i) | (irq_src & irq_enable_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_pending_o <= '0;
    end else begin
      irq_pending_o <= pending_next;
    end
  end

  // Shared open-drain line: drive low only while an enabled source pends.
  // Data is tied low and only the enable moves, so the line can
  // never be driven high against other boards sharing it.
  // Dropping an enable releases the line but leaves the pending
  // bit for software to inspect and clear.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pci_inta_n_o <= 1'b0;
      pci_inta_oe_n_o <= 1'b1;
    end else begin
      pci_inta_n_o <= 1'b0;
      pci_inta_oe_n_o <= ~|(pending_next & irq_enable_i);
    end
  end

endmodule // daqtr_top

// >>> tb/daqtr_chk.sv
// Port-level assertions for the trigger routing block
`timescale 1ns/1ns
module daqtr_chk #(
  parameter int FAST_DIV_P = 5,
  parameter int SLOW_DIV_P = 500
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire daqtr_pkg::daqtr_evt_s evt_i,
  input wire logic [daqtr_pkg::CTR_N-1:0][daqtr_pkg::CCLK_SEL_W-1:0] ctr_clk_sel_i,
  input wire logic [daqtr_pkg::CTR_N-1:0] ctr_clk_en_o,
  input wire logic [daqtr_pkg::IRQ_N-1:0] irq_enable_i,
  input wire logic [daqtr_pkg::IRQ_N-1:0] irq_clear_i,
  input wire logic [daqtr_pkg::IRQ_N-1:0] irq_pending_o,
  input wire logic scan_begin_pulse_o,
  input wire logic sample_hold_window_o,
  input wire logic acq_stop_o,
  input wire logic pci_inta_n_o,
  input wire logic pci_inta_oe_n_o
);
  import daqtr_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  line_data_a: assert property (pci_inta_n_o == 1'b0)
    else $error("interrupt line data not low");
  line_cause_a: assert property (!pci_inta_oe_n_o |-> |irq_pending_o)
    else $error("interrupt line driven with nothing pending");
  sample_irq_a: assert property (evt_i.sample_done && irq_enable_i[IRQ_PER_SAMPLE]
    |=> irq_pending_o[IRQ_PER_SAMPLE] && !pci_inta_oe_n_o)
    else $error("per-sample event not signalled");
  done_irq_a: assert property (evt_i.acq_done && irq_enable_i[IRQ_ACQ_COMPLETE]
    |=> irq_pending_o[IRQ_ACQ_COMPLETE]) else $error("completion event lost");
  run_irq_a: assert property (evt_i.acq_active && irq_enable_i[IRQ_ACQ_RUNNING]
    |=> irq_pending_o[IRQ_ACQ_RUNNING]) else $error("running level lost");
  gated_set_a: assert property ($rose(irq_pending_o[IRQ_ACQ_COMPLETE])
    |-> $past(irq_enable_i[IRQ_ACQ_COMPLETE])) else $error("disabled source pended");
  clear_irq_a: assert property (irq_clear_i[IRQ_PER_SAMPLE] && !evt_i.sample_done
    |=> !irq_pending_o[IRQ_PER_SAMPLE]) else $error("pending not cleared");
  scan_pulse_a: assert property (scan_begin_pulse_o == $past(evt_i.scan_start))
    else $error("scan begin pulse wrong");
  hold_end_a: assert property (evt_i.last_conv_start |=> !sample_hold_window_o)
    else $error("hold window not closed");
  hold_open_a: assert property (evt_i.scan_start && !evt_i.last_conv_start
    |=> sample_hold_window_o) else $error("hold window not opened");
  scan_stop_a: assert property (evt_i.scan_end |=> acq_stop_o)
    else $error("scan end not shown");
  fast_tick_a: assert property (ctr_clk_en_o[0] && ctr_clk_sel_i[0] == CCLK_FAST
    |=> !ctr_clk_en_o[0] [*4] ##1 ctr_clk_en_o[0]) else $error("fast tick period wrong");
  no_clock_a: assert property (ctr_clk_sel_i[1] == 2'h3 && $past(ctr_clk_sel_i[1], 2) == 2'h3
    |-> !ctr_clk_en_o[1]) else $error("counter ticks with no source");
endmodule // daqtr_chk

bind daqtr_top daqtr_chk #(.FAST_DIV_P(FAST_DIV_P), .SLOW_DIV_P(SLOW_DIV_P)) chk_u (
  .clk_sys_i, .rst_n_i, .evt_i, .ctr_clk_sel_i, .ctr_clk_en_o, .irq_enable_i,
  .irq_clear_i, .irq_pending_o, .scan_begin_pulse_o, .sample_hold_window_o,
  .acq_stop_o, .pci_inta_n_o, .pci_inta_oe_n_o
);

// >>> tb/daqtr_wiring.sv
// Model of the external trigger pins and counter clock wiring
`timescale 1ns/1ns
module daqtr_wiring (
  // Clock
  input wire logic clk_sys_i,
  // Pins towards the block
  output logic [daqtr_pkg::AUX_IN_N-1:0] aux_pin_o,
  output logic [daqtr_pkg::CTR_N-1:0] ext_clk_o
);
  import daqtr_pkg::*;
  logic [AUX_IN_N-1:0] idle_reg = '0;
  logic [AUX_IN_N-1:0] act_reg = '0;
  // Idle level chosen by the bench; a pulse drives the opposite level
  assign aux_pin_o = idle_reg ^ act_reg;
  initial ext_clk_o = '0;
  // Pulse held for len whole clocks; a len of zero gives no pulse at all
  task automatic pulse(input int idx, input int len);
    @(posedge clk_sys_i);
    act_reg[idx] <= 1'b1;
    repeat (len) @(posedge clk_sys_i);
    act_reg[idx] <= 1'b0;
  endtask
  // Edges every six clocks, about 8.3 MHz from the 50 MHz clock
  task automatic burst(input int idx, input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      ext_clk_o[idx] <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      ext_clk_o[idx] <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
endmodule // daqtr_wiring

// >>> tb/daqtr_top_tb.sv
// Self-checking bench for the trigger routing block
`timescale 1ns/1ns
module daqtr_top_tb;
  import daqtr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire [AUX_IN_N-1:0] aux_in;
  wire [CTR_N-1:0] ext_clk;
  logic [AUX_OUT_N-1:0] aux_out;
  logic [AUX_IN_N-1:0][AIN_SEL_W-1:0] ain_sel = '0;
  logic [AUX_IN_N-1:0] ain_inv = '0;
  logic [AUX_OUT_N-1:0][AOUT_SEL_W-1:0] aout_sel = '0;
  logic [AUX_OUT_N-1:0] aout_inv = '0;
  logic gate_edge = 1'b0;
  logic gate_clr = 1'b0;
  daqtr_evt_s evt = '0;
  daqtr_route_s route;
  logic scan_pulse, hold_win, acq_stop, inta_n, inta_oe_n;
  logic [CTR_N-1:0] clk_en;
  logic [CTR_N-1:0][CCLK_SEL_W-1:0] cclk_sel = {CCLK_SLOW, CCLK_FAST};
  logic [IRQ_N-1:0] irq_en = '0;
  logic [IRQ_N-1:0] irq_clr = '0;
  logic [IRQ_N-1:0] pend;
  logic [15:0] acc, ao_or, ao_and, exp;
  int errors = 0;
  int n_compared = 0;
  int c0, c1;
  // Event bit that feeds each source; the halt source comes from a pin
  int evb[IRQ_N] = '{14, -1, 13, 12, 11, 10, 9, 8, 7, 6, 5};
  int rtb[8] = '{8, 7, 6, 5, 4, 3, 1, 0};
  int aoc[5] = '{0, 2, 3, 4, 6};
  int aob[5] = '{4, 10, 3, 1, 0};

  daqtr_top #(.SLOW_DIV_P(10)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .aux_trigger_input_i(aux_in),
    .aux_trigger_output_o(aux_out), .ain_sel_i(ain_sel), .ain_invert_i(ain_inv),
    .aout_sel_i(aout_sel), .aout_invert_i(aout_inv), .dac_gate_edge_mode_i(gate_edge),
    .dac_gate_clear_i(gate_clr), .evt_i(evt), .route_o(route),
    .scan_begin_pulse_o(scan_pulse), .sample_hold_window_o(hold_win),
    .acq_stop_o(acq_stop), .counter_ext_clock_i(ext_clk), .ctr_clk_sel_i(cclk_sel),
    .ctr_clk_en_o(clk_en), .irq_enable_i(irq_en), .irq_clear_i(irq_clr),
    .irq_pending_o(pend), .pci_inta_n_o(inta_n), .pci_inta_oe_n_o(inta_oe_n)
  );
  daqtr_wiring wire_u (.clk_sys_i(clk_sys_i), .aux_pin_o(aux_in), .ext_clk_o(ext_clk));

  initial forever #10 clk_sys_i = ~clk_sys_i;

  task automatic chk_v(input string what, input logic [15:0] e, input logic [15:0] got);
    n_compared++;
    if (got !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic chk_n(input string what, input int e, input int got);
    n_compared++;
    if (got != e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, e, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // One-cycle event pulse
  task automatic ev(input int b);
    @(posedge clk_sys_i);
    evt[b] <= 1'b1;
    @(posedge clk_sys_i);
    evt <= '0;
  endtask
  task automatic clr(input logic [IRQ_N-1:0] m);
    @(posedge clk_sys_i);
    irq_clr <= m;
    @(posedge clk_sys_i);
    irq_clr <= '0;
  endtask
  // Collects routed functions and aux outputs over settled samples
  task automatic watch(input int n);
    acc = '0;
    ao_or = '0;
    ao_and = '1;
    repeat (n) begin
      @(negedge clk_sys_i);
      acc |= 16'(route);
      ao_or |= 16'(aux_out);
      ao_and &= {13'h1fff, aux_out};
    end
  endtask
  task automatic count(input int n);
    c0 = 0;
    c1 = 0;
    repeat (n) begin
      @(negedge clk_sys_i);
      c0 += int'(clk_en[0] === 1'b1);
      c1 += int'(clk_en[1] === 1'b1);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard: the whole run is far shorter than this
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end

  initial begin
    @(negedge clk_sys_i);
    chk_v("reset outs", 16'h0001, {aux_out, scan_pulse, hold_win, acq_stop, inta_n, inta_oe_n});
    tk(5);
    rst_n_i <= 1'b1;
    tk(4);
    // Every source but the halt one: refused while disabled, then pending, line, drop, clear
    for (int k = 0; k < IRQ_N; k++) begin
      if (evb[k] < 0) continue;
      ev(evb[k]);
      @(negedge clk_sys_i);
      chk_v("disabled", 16'h0001, {pend, inta_oe_n});
      @(posedge clk_sys_i);
      irq_en <= 11'h1 << k;
      ev(evb[k]);
      @(negedge clk_sys_i);
      chk_v("pending", 16'(11'h1 << k), 16'(pend));
      chk_v("line on", 16'h0, 16'(inta_oe_n));
      @(posedge clk_sys_i);
      irq_en <= '0;
      tk(2);
      @(negedge clk_sys_i);
      chk_v("line off kept", {4'h0, 11'h1 << k, 1'b1}, {4'h0, pend, inta_oe_n});
      clr(11'h1 << k);
      @(negedge clk_sys_i);
      chk_v("cleared", 16'h0, 16'(pend));
    end
    $display("test irq sources done");
    // Each input function at both polarities
    @(posedge clk_sys_i);
    irq_en <= '1;
    for (int v = 0; v < 2; v++) begin
      for (int f = 0; f < 8; f++) begin
        @(posedge clk_sys_i);
        ain_sel[0] <= 3'(f);
        ain_inv[0] <= v[0];
        wire_u.idle_reg[0] <= v[0];
        tk(8);
        clr('1);
        fork
          wire_u.pulse(0, 3);
          watch(12);
        join
        exp = (16'h1 << rtb[f]) | ((f == 5) ? 16'h4 : 16'h0);
        chk_v("route", exp, acc);
        chk_v("halt irq", (f == 3) ? 16'h2 : 16'h0, 16'(pend));
      end
    end
    // Edge gating stays open until cleared
    @(posedge clk_sys_i);
    ain_sel[0] <= AIN_DAC_START;
    ain_inv[0] <= 1'b0;
    wire_u.idle_reg[0] <= 1'b0;
    gate_edge <= 1'b1;
    tk(8);
    wire_u.pulse(0, 3);
    tk(6);
    @(negedge clk_sys_i);
    chk_v("edge gate", 16'h1, 16'(route.dac_gate));
    @(posedge clk_sys_i);
    gate_clr <= 1'b1;
    @(posedge clk_sys_i);
    gate_clr <= 1'b0;
    tk(1);
    @(negedge clk_sys_i);
    chk_v("gate closed", 16'h0, 16'(route.dac_gate));
    $display("test aux inputs done");
    // Output selection, with the middle output inverted
    @(posedge clk_sys_i);
    aout_inv <= 3'b010;
    for (int s = 0; s < 5; s++) begin
      @(posedge clk_sys_i);
      aout_sel <= {3{4'(aoc[s])}};
      tk(3);
      fork
        ev(aob[s]);
        watch(6);
      join
      chk_v("aux out", 16'h0007, ao_or);
      chk_v("aux out low", 16'hfff8, ao_and);
    end
    @(posedge clk_sys_i);
    aout_sel <= {3{4'hb}};
    tk(3);
    @(negedge clk_sys_i);
    chk_v("unused source", 16'h2, 16'(aux_out));
    ev(2);
    @(negedge clk_sys_i);
    chk_v("hold shut first", 16'h0, 16'(hold_win));
    ev(4);
    @(negedge clk_sys_i);
    chk_v("hold open", 16'h1, 16'(hold_win));
    ev(2);
    @(negedge clk_sys_i);
    chk_v("hold closed", 16'h0, 16'(hold_win));
    // Sample-hold window and a start-trigger echo on the outputs
    @(posedge clk_sys_i);
    aout_sel <= {3{4'h1}};
    ev(4);
    tk(1);
    @(negedge clk_sys_i);
    chk_v("hold out", 16'h5, 16'(aux_out));
    @(posedge clk_sys_i);
    aout_sel <= {3{4'h8}};
    ain_sel[0] <= AIN_ADC_START;
    gate_edge <= 1'b0;
    tk(8);
    fork
      wire_u.pulse(0, 3);
      watch(12);
    join
    chk_v("echo out", 16'h0007, ao_or);
    chk_v("echo out low", 16'hfff8, ao_and);
    $display("test aux outputs done");
    // Counter clock sources
    count(100);
    chk_n("fast ticks", 20, c0);
    chk_n("slow ticks", 10, c1);
    @(posedge clk_sys_i);
    cclk_sel[1] <= CCLK_EXT;
    tk(4);
    fork
      wire_u.burst(1, 7);
      count(60);
    join
    chk_n("pin ticks", 7, c1);
    @(posedge clk_sys_i);
    cclk_sel[1] <= 2'h3;
    tk(4);
    count(50);
    chk_n("no ticks", 0, c1);
    $display("test counter clocks done");
    end_of_test();
  end
endmodule // daqtr_top_tb
